//--- logic/quad_dac_pkg.sv
// Purpose: Shared constants and types for the quad converter serial write
// Assumes: 40 MHz system clock on both ends
// Notes: Word layout is channel(2), mode(2), code(12), first bit sent first

package quad_dac_pkg;

  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int WORD_BITS = 16;
  localparam int WORD_MSB = 15;
  localparam int SHIFT_MSB = 14;
  localparam int CHAN_HI = 15;
  localparam int CHAN_LO = 14;
  localparam int MODE_HI = 13;
  localparam int MODE_LO = 12;
  localparam int DATA_BITS = 12;
  localparam int DATA_MSB = 11;
  localparam int CHANNELS = 4;

  // Falling edge counter: index of the last bit and the done value
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam logic [4:0] EDGES_DONE = 5'h10;
  localparam logic [4:0] EDGE_STEP = 5'h01;
  localparam logic [3:0] LAST_BIT = 4'hF;

  // Reset value of every channel code
  localparam logic [11:0] CODE_ZERO = 12'h000;

  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0]
  {
    MODE_LOAD_ONE = 2'b00,
    MODE_LOAD_UPDATE = 2'b01,
    MODE_LOAD_ALL = 2'b10,
    MODE_POWER_DOWN = 2'b11
  } op_mode_t;

  typedef enum logic [1:0]
  {
    TERM_HIZ = 2'b00,
    TERM_PULL_2K5 = 2'b01,
    TERM_PULL_100K = 2'b10,
    TERM_HIZ_ALT = 2'b11
  } term_t;

  typedef logic [CHANNELS-1:0][DATA_BITS-1:0] code_bank_t;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 40;
  localparam int WAKE_3V_NS = 800;
  localparam int WAKE_5V_NS = 500;
  localparam int SYNC_HIGH_NS = 6;
  localparam int SCLK_MAX_MHZ = 40;
  // Typical wake times round down, least high time rounds up
  localparam int WAKE_3V_CYC = WAKE_3V_NS * CLK_MHZ / 1000;
  localparam int WAKE_5V_CYC = WAKE_5V_NS * CLK_MHZ / 1000;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_W = $clog2(WAKE_3V_CYC + 1);
  localparam int HOLD_W = 4;
  localparam logic [WAKE_W-1:0] WAKE_ONE = WAKE_W'(1);
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);

endpackage

//--- logic/serial_write_if.sv
// Purpose: Three wire write link between host and converter
// Assumes: Host drives every wire, device only listens
// Notes: frame_sync_n low marks a write frame

`timescale 1ns/1ps

interface serial_write_if;
  logic frame_sync_n;
  logic sclk;
  logic sdata;

  modport host
  (
    output frame_sync_n,
    output sclk,
    output sdata
  );

  modport device
  (
    input frame_sync_n,
    input sclk,
    input sdata
  );
endinterface

//--- logic/quad_dac_device.sv
// Purpose: Converter end: serial word capture, command decode, outputs
// Assumes: sclk from the host clocks the link side; clk runs free
// Notes: Link state crosses to clk by a toggle; wake time counted on clk

`timescale 1ns/1ps

module quad_dac_device
#(
  parameter bit high_supply = 1'b0
)
(
  input wire logic clk,
  input wire logic resetn,
  serial_write_if.device link,
  output quad_dac_pkg::code_bank_t dac_code,
  output logic out_enable,
  output logic powered_down,
  output quad_dac_pkg::term_t term_mode
);

  // ************************************************************
  // Types and constants
  // ************************************************************

  // Frame progress, cleared whenever frame sync is high
  typedef struct packed {
    logic [4:0] edges;
    logic [quad_dac_pkg::SHIFT_MSB:0] shift;
  } frame_t;

  // Link side command results
  typedef struct packed {
    quad_dac_pkg::code_bank_t held;
    quad_dac_pkg::code_bank_t live;
    logic pd;
    quad_dac_pkg::term_t term;
    logic tog;
  } link_t;

  // System clock side outputs and crossing
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    quad_dac_pkg::code_bank_t code;
    logic enable;
    logic pd;
    quad_dac_pkg::term_t term;
    logic [quad_dac_pkg::WAKE_W-1:0] wake;
  } core_t;

  localparam logic [quad_dac_pkg::WAKE_W-1:0] WAKE_CYC = high_supply ?
    quad_dac_pkg::WAKE_W'(quad_dac_pkg::WAKE_5V_CYC) :
    quad_dac_pkg::WAKE_W'(quad_dac_pkg::WAKE_3V_CYC);

  localparam frame_t FRAME_RST = '{
    edges: 5'h00,
    shift: '0
  };

  localparam link_t LINK_RST = '{
    held: {quad_dac_pkg::CHANNELS{quad_dac_pkg::CODE_ZERO}},
    live: {quad_dac_pkg::CHANNELS{quad_dac_pkg::CODE_ZERO}},
    pd: 1'b0,
    term: quad_dac_pkg::TERM_HIZ,
    tog: 1'b0
  };

  localparam core_t CORE_RST = '{
    s1: 1'b0,
    s2: 1'b0,
    s3: 1'b0,
    code: {quad_dac_pkg::CHANNELS{quad_dac_pkg::CODE_ZERO}},
    enable: 1'b1,
    pd: 1'b0,
    term: quad_dac_pkg::TERM_HIZ,
    wake: '0
  };

  frame_t frm_q;
  frame_t frm_d;
  link_t lnk_q;
  link_t lnk_d;
  core_t core_q;
  core_t core_d;
  logic frame_clr;
  logic [quad_dac_pkg::WORD_MSB:0] word;
  logic [1:0] chan;
  quad_dac_pkg::op_mode_t mode;
  logic [quad_dac_pkg::DATA_MSB:0] data;

  // ************************************************************
  // Link side decode
  // ************************************************************

  assign frame_clr = link.frame_sync_n | ~resetn;

  // Next state for the frame counter and the command registers
  always_comb
  begin
    word = {frm_q.shift, link.sdata};
    chan = word[quad_dac_pkg::CHAN_HI:quad_dac_pkg::CHAN_LO];
    mode = quad_dac_pkg::op_mode_t'(
      word[quad_dac_pkg::MODE_HI:quad_dac_pkg::MODE_LO]);
    data = word[quad_dac_pkg::DATA_MSB:0];
    frm_d = frm_q;
    lnk_d = lnk_q;
    if (frm_q.edges != quad_dac_pkg::EDGES_DONE)
    begin
      frm_d.shift = word[quad_dac_pkg::SHIFT_MSB:0];
      frm_d.edges = frm_q.edges + quad_dac_pkg::EDGE_STEP;
    end
    if (frm_q.edges == quad_dac_pkg::LAST_EDGE)
    begin
      lnk_d.tog = ~lnk_q.tog;
      case (mode)
        quad_dac_pkg::MODE_LOAD_ONE:
        begin
          lnk_d.held[chan] = data;
          lnk_d.pd = 1'b0;
        end
        quad_dac_pkg::MODE_LOAD_UPDATE:
        begin
          lnk_d.held[chan] = data;
          lnk_d.live = lnk_d.held;
          lnk_d.pd = 1'b0;
        end
        quad_dac_pkg::MODE_LOAD_ALL:
        begin
          for (int i = 0; i < quad_dac_pkg::CHANNELS; i++)
          begin
            lnk_d.held[i] = data;
          end
          lnk_d.live = lnk_d.held;
          lnk_d.pd = 1'b0;
        end
        quad_dac_pkg::MODE_POWER_DOWN:
        begin
          lnk_d.pd = 1'b1;
          lnk_d.term = quad_dac_pkg::term_t'(chan);
        end
        default:
        begin
          lnk_d.pd = lnk_q.pd;
        end
      endcase
    end
  end

  // ************************************************************
  // Link side registers
  // ************************************************************

  // Frame counter on falling sclk, held clear while frame is high
  // Counting starts at frame fall
  always_ff @(negedge link.sclk or posedge frame_clr)
  begin
    if (frame_clr)
      frm_q <= FRAME_RST;
    else
      frm_q <= frm_d;
  end

  // Command registers on falling sclk
  // Cleared at power-up
  always_ff @(negedge link.sclk or negedge resetn)
  begin
    if (!resetn)
      lnk_q <= LINK_RST;
    else
      lnk_q <= lnk_d;
  end

  // ************************************************************
  // System clock side
  // ************************************************************

  // Toggle synchroniser, copy of results and wake timer
  always_comb
  begin
    core_d = core_q;
    core_d.s1 = lnk_q.tog;
    core_d.s2 = core_q.s1;
    core_d.s3 = core_q.s2;
    if (core_q.wake != '0)
    begin
      core_d.wake = core_q.wake - quad_dac_pkg::WAKE_ONE;
      if (core_q.wake == quad_dac_pkg::WAKE_ONE)
        core_d.enable = 1'b1;
    end
    // Link data has been stable since the toggle flipped
    if (core_q.s2 != core_q.s3)
    begin
      core_d.code = lnk_q.live;
      core_d.term = lnk_q.term;
      if (lnk_q.pd)
      begin
        core_d.pd = 1'b1;
        core_d.enable = 1'b0;
        core_d.wake = '0;
      end
      else if (core_q.pd)
      begin
        core_d.pd = 1'b0;
        core_d.wake = WAKE_CYC;
      end
    end
  end

  // System clock registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      core_q <= CORE_RST;
    else
      core_q <= core_d;
  end

  // Outputs come straight from the system clock registers
  assign dac_code = core_q.code;
  assign out_enable = core_q.enable;
  assign powered_down = core_q.pd;
  assign term_mode = core_q.term;

endmodule

//--- logic/quad_dac_host.sv
// Purpose: Host end: sends one sixteen bit write per accepted command
// Assumes: sclk made by dividing clk by two
// Notes: Lines idle low with the clock stopped between writes

`timescale 1ns/1ps

module quad_dac_host
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_channel,
  input wire quad_dac_pkg::op_mode_t cmd_mode,
  input wire logic [quad_dac_pkg::DATA_MSB:0] cmd_data,
  serial_write_if.host link
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SYNC_HI = 2'b01,
    ST_SHIFT = 2'b10,
    ST_DONE = 2'b11
  } state_t;

  typedef struct packed {
    state_t state;
    logic [quad_dac_pkg::WORD_MSB:0] word;
    logic [3:0] bits;
    logic phase;
    logic [quad_dac_pkg::HOLD_W-1:0] hold;
    logic frame_n;
    logic sclk;
    logic sdata;
    logic ready;
  } host_t;

  localparam logic [quad_dac_pkg::HOLD_W-1:0] HOLD_CYC =
    quad_dac_pkg::HOLD_W'(quad_dac_pkg::SYNC_HIGH_CYC);

  localparam host_t HOST_RST = '{
    state: ST_IDLE,
    word: '0,
    bits: 4'h0,
    phase: 1'b0,
    hold: '0,
    frame_n: 1'b0,
    sclk: 1'b0,
    sdata: 1'b0,
    ready: 1'b1
  };

  host_t h_q;
  host_t h_d;

  // ************************************************************
  // Sequencer
  // ************************************************************

  // Frame high, then sixteen sclk periods of two clk cycles each
  always_comb
  begin
    h_d = h_q;
    case (h_q.state)
      ST_IDLE:
      begin
        if (cmd_valid && h_q.ready)
        begin
          h_d.word = {cmd_channel, cmd_mode, cmd_data};
          h_d.frame_n = 1'b1;
          h_d.sclk = 1'b1;
          h_d.ready = 1'b0;
          h_d.hold = HOLD_CYC - quad_dac_pkg::HOLD_ONE;
          h_d.state = ST_SYNC_HI;
        end
      end
      ST_SYNC_HI:
      begin
        if (h_q.hold == '0)
        begin
          h_d.frame_n = 1'b0;
          h_d.sdata = h_q.word[quad_dac_pkg::WORD_MSB];
          h_d.bits = 4'h0;
          h_d.phase = 1'b0;
          h_d.state = ST_SHIFT;
        end
        else
          h_d.hold = h_q.hold - quad_dac_pkg::HOLD_ONE;
      end
      ST_SHIFT:
      begin
        if (!h_q.phase)
        begin
          h_d.sclk = 1'b0;
          h_d.phase = 1'b1;
        end
        else if (h_q.bits == quad_dac_pkg::LAST_BIT)
        begin
          h_d.sdata = 1'b0;
          h_d.state = ST_DONE;
        end
        else
        begin
          h_d.bits = h_q.bits + 4'h1;
          h_d.word = {h_q.word[quad_dac_pkg::SHIFT_MSB:0], 1'b0};
          h_d.sdata = h_q.word[quad_dac_pkg::SHIFT_MSB];
          h_d.sclk = 1'b1;
          h_d.phase = 1'b0;
        end
      end
      ST_DONE:
      begin
        h_d.ready = 1'b1;
        h_d.state = ST_IDLE;
      end
      default:
      begin
        h_d = HOST_RST;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      h_q <= HOST_RST;
    else
      h_q <= h_d;
  end

  assign cmd_ready = h_q.ready;
  assign link.frame_sync_n = h_q.frame_n;
  assign link.sclk = h_q.sclk;
  assign link.sdata = h_q.sdata;

endmodule

//--- bench/quad_dac_properties.sv
// Purpose: Timing checks on the write link and converter outputs
// Assumes: Host makes sclk from clk, so clk sees every sclk edge
// Notes: Fall counter follows sclk as sampled on clk
`timescale 1ns/1ps
module quad_dac_properties
(
  input logic clk,
  input logic resetn,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic frame_sync_n,
  input logic sclk,
  input logic sdata,
  input quad_dac_pkg::code_bank_t dac_code,
  input logic out_enable,
  input logic powered_down,
  input quad_dac_pkg::term_t term_mode
);
  logic [4:0] fall_cnt_q;
  logic sclk_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counts sclk falls inside a frame, cleared while frame is high
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fall_cnt_q <= 5'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (frame_sync_n)
        fall_cnt_q <= 5'h00;
      else if (sclk_q && !sclk)
        fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  // Link checks
  take_frame_a: assert property (
    (cmd_valid && cmd_ready) |=> frame_sync_n && sclk && !cmd_ready)
    else $error("frame did not open after take");
  sync_off_fall_a: assert property (
    $fell(frame_sync_n) |-> sclk && $stable(sclk))
    else $error("frame fell with sclk moving");
  frame_gap_a: assert property (
    $rose(frame_sync_n) |=> !frame_sync_n)
    else $error("frame high span wrong");
  data_setup_a: assert property (
    (!frame_sync_n && $fell(sclk)) |-> $stable(sdata))
    else $error("data moved at sampling fall");
  word_len_a: assert property (
    $rose(cmd_ready) |-> fall_cnt_q == 5'h10)
    else $error("word not sixteen falls");
  idle_low_a: assert property (
    cmd_ready |-> !frame_sync_n && !sclk && !sdata)
    else $error("lines not idle low");
  // Output checks
  down_keeps_a: assert property (
    $rose(powered_down) |-> $stable(dac_code) && !out_enable)
    else $error("codes moved entering power-down");
  term_down_a: assert property (
    $changed(term_mode) |-> powered_down)
    else $error("termination changed outside power-down");
  wake_time_a: assert property (
    $fell(powered_down) |-> (!out_enable)[*8] ##[22:26] out_enable)
    else $error("wake time out of range");

  cover property ((cmd_valid && cmd_ready) ##1 !cmd_ready);
  cover property ($rose(powered_down));
  cover property ($fell(powered_down));
endmodule

//--- bench/tb_top.sv
// Purpose: Host and converter joined, plus a bench driven converter
// Assumes: clk 25 ns; bench link clock 160 ns, only inside frames
// Notes: Second link breaks framing on purpose
`timescale 1ns/1ps
module tb_top;
  logic clk, resetn, cmd_valid, cmd_ready;
  logic [1:0] cmd_channel;
  quad_dac_pkg::op_mode_t cmd_mode;
  logic [11:0] cmd_data;
  quad_dac_pkg::code_bank_t code_a, code_b;
  quad_dac_pkg::term_t term_a, term_b;
  logic oe_a, oe_b, pd_a, pd_b;
  int n_mismatch, total_checks;
  serial_write_if link_a();
  serial_write_if link_b();

  // Host and converter face each other on link_a
  quad_dac_host quad_dac_host_i (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_channel(cmd_channel), .cmd_mode(cmd_mode),
    .cmd_data(cmd_data), .link(link_a.host));
  quad_dac_device quad_dac_device_i (.clk(clk), .resetn(resetn),
    .link(link_a.device), .dac_code(code_a), .out_enable(oe_a),
    .powered_down(pd_a), .term_mode(term_a));
  // Bench driven converter runs with the short wake time
  quad_dac_device #(.high_supply(1'b1)) quad_dac_device_b_i (.clk(clk),
    .resetn(resetn),
    .link(link_b.device), .dac_code(code_b), .out_enable(oe_b),
    .powered_down(pd_b), .term_mode(term_b));
  quad_dac_properties props_i (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .frame_sync_n(link_a.frame_sync_n), .sclk(link_a.sclk),
    .sdata(link_a.sdata), .dac_code(code_a), .out_enable(oe_a),
    .powered_down(pd_a), .term_mode(term_a));

  // Free running system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_code(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: code %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  // One command through the host, then wait out word and crossing
  task automatic send(input logic [1:0] ch,
    input quad_dac_pkg::op_mode_t md, input logic [11:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_channel = ch;
    cmd_mode = md;
    cmd_data = d;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (44) @(negedge clk);
  endtask

  // Bench frame on link_b: nf falls, sclk still outside the frame
  task automatic frame_b(input logic [15:0] w, input int nf, input bit rise);
    link_b.frame_sync_n = 1'b1;
    #80 link_b.frame_sync_n = 1'b0;
    #40;
    for (int i = 0; i < nf; i++)
    begin
      link_b.sdata = (i < 16) ? w[15 - i] : 1'b1;
      link_b.sclk = 1'b1;
      #80 link_b.sclk = 1'b0;
      #80;
    end
    link_b.sdata = 1'b0;
    if (rise)
    begin
      link_b.frame_sync_n = 1'b1;
      #80 link_b.frame_sync_n = 1'b0;
    end
    repeat (10) @(negedge clk);
  endtask

  task automatic t_reset();
    for (int c = 0; c < 4; c++)
    begin
      cmp_code(code_a[c], 12'h000);
      cmp_code(code_b[c], 12'h000);
    end
    cmp_bit(oe_a, 1'b1);
    cmp_bit(pd_a, 1'b0);
  endtask

  task automatic t_load();
    logic [11:0] v [4] = '{12'h800, 12'h001, 12'hFFF, 12'h5A5};
    send(2'h1, quad_dac_pkg::MODE_LOAD_ONE, 12'hABC);
    cmp_code(code_a[1], 12'h000);
    send(2'h2, quad_dac_pkg::MODE_LOAD_UPDATE, 12'h123);
    cmp_code(code_a[1], 12'hABC);
    cmp_code(code_a[2], 12'h123);
    for (int c = 0; c < 4; c++)
    begin
      send(2'(c), quad_dac_pkg::MODE_LOAD_UPDATE, v[c]);
      cmp_code(code_a[c], v[c]);
    end
    send(2'h3, quad_dac_pkg::MODE_LOAD_ALL, 12'h7E1);
    for (int c = 0; c < 4; c++)
      cmp_code(code_a[c], 12'h7E1);
  endtask

  task automatic t_power();
    int n;
    n = 0;
    for (int t = 0; t < 4; t++)
    begin
      send(2'(t), quad_dac_pkg::MODE_POWER_DOWN, 12'hFFF);
      cmp_bit(pd_a, 1'b1);
      cmp_bit(term_a === quad_dac_pkg::term_t'(t), 1'b1);
      cmp_code(code_a[t], 12'h7E1);
    end
    send(2'h0, quad_dac_pkg::MODE_LOAD_UPDATE, 12'h321);
    cmp_bit(pd_a, 1'b0);
    while (oe_a !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    cmp_bit(n >= 20 && n <= 30, 1'b1);
    cmp_code(code_a[0], 12'h321);
    cmp_code(code_a[1], 12'h7E1);
  endtask

  task automatic t_framing();
    int n;
    n = 0;
    frame_b({2'h3, 2'h1, 12'h9C3}, 19, 1'b1);
    cmp_code(code_b[3], 12'h9C3);
    cmp_bit(pd_b, 1'b0);
    frame_b({2'h0, 2'h2, 12'hFFF}, 10, 1'b1);
    for (int c = 0; c < 3; c++)
      cmp_code(code_b[c], 12'h000);
    frame_b({2'h0, 2'h1, 12'h456}, 16, 1'b0);
    cmp_code(code_b[0], 12'h456);
    frame_b({2'h2, 2'h3, 12'h000}, 16, 1'b1);
    cmp_bit(pd_b, 1'b1);
    cmp_bit(term_b === quad_dac_pkg::TERM_PULL_100K, 1'b1);
    // Load only ends power-down; short wake lands about 7 clk later
    frame_b({2'h1, 2'h0, 12'h0AA}, 16, 1'b1);
    cmp_bit(pd_b, 1'b0);
    cmp_bit(oe_b, 1'b0);
    while (oe_b !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    cmp_bit(n >= 5 && n <= 9, 1'b1);
    cmp_code(code_b[0], 12'h456);
    cmp_code(code_b[1], 12'h000);
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_channel = 2'h0;
    cmd_mode = quad_dac_pkg::MODE_LOAD_ONE;
    cmd_data = 12'h000;
    link_b.frame_sync_n = 1'b0;
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_load();
    t_power();
    t_framing();
    report_and_stop();
  end

  // Watchdog against a hang
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
